// >>> design/sdpd_pkg.sv
// Constants shared by the power-down clock-enable control block.
package sdpd_pkg;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EXITCNT = 8'h08;
  // Control register field positions.
  localparam int CTRL_SLOW_EXIT = 0;
  localparam int CTRL_ODT_EN = 1;
  localparam int CTRL_DLL_LOCKED = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  // Command encoding on cs, ras, cas, we (all active low).
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_LM = 4'h0;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  // Exit delays in memory clocks.
  localparam int EXIT_NONREAD_CLK = 2;
  localparam int FAST_READ_CLK = 2;
  localparam int SLOW_READ_CLK = 6;
  localparam int SR_NONREAD_CLK = 200;
  localparam int SR_READ_CLK = 200;
  localparam int CKE_MIN_CLK = 3;
  // Operating states.
  typedef enum logic [2:0] {
    SDPD_IDLE = 3'b000,
    SDPD_ACTIVE = 3'b001,
    SDPD_PRE_PD = 3'b010,
    SDPD_ACT_PD = 3'b011,
    SDPD_SELF_REF = 3'b100
  } sdpd_state_t;
endpackage : sdpd_pkg

// >>> design/sdpd_sync.sv
// Two-stage synchroniser with rising-edge detect on the synced level.
`timescale 1ns/1ps
module sdpd_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout,
  output logic rise
);
  // First stage, read only by the second stage.
  logic meta;
  // Previous synced value for edge detection.
  logic last;
  // Synchronising chain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
      last <= dout;
    end
  end
  // One-cycle pulse on a rising synced edge.
  assign rise = dout & ~last;
endmodule : sdpd_sync

// >>> design/sdpd_top.sv
// Power-down and self-refresh clock-enable state control of the memory.
// Notes on behaviour
// (R1) Idle entry is precharge, open row is active.
// (R2) Controller holds clock enable three edges.
// (R3) Controller waits exit delay before non-read.
// (R4) Fast exit uses short active-exit read delay.
// (R5) Slow exit uses long active-exit read delay.
// (R6) No power-down during column access.
// (R7) Unlocked loop needs reset after exit; the loop-locked control bit is stored and read back but never acted on.
// (R8) Entry and exit only with nop/deselect.
// (R9) Self refresh on refresh with enable falling.
// (R10) Self-refresh exit: nops, reads after 200.
// (R11) Low enable holds state, ignores commands.
// (R12) No refresh performed during power-down.
// (R13) Termination pin driven valid in power-down.
// (R14) No termination in self refresh.
// (R15) No entry during read, write, load, precharge.
// (R16) Unlisted enable/command pairs are illegal.
// (R17) Entry only after read burst completes.
// (R18) Entry one clock after write precharge start.
// (R19) Write recovery field is rounded up.
// (R20) Precharge power-down one clock after refresh.
// (R21) Active power-down one clock after activate.
// (R22) Precharge power-down one clock after precharge.
// (R23) Load needs idle banks; entry after load delay.
// (R24) Freeze loop in precharge power-down; buffers off.
// (R25) Keep previous clock-enable sample.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module sdpd_top (
  input wire logic aclk,
  input wire logic aresetn,
  // Memory-side pins, all from the link domain.
  input wire logic mem_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic termination_control_pin,
  // Device status outputs.
  output logic termination_on,
  output logic dll_frozen,
  output logic buffers_on,
  output logic refreshing,
  output logic read_ready,
  output logic nonread_ready,
  output logic illegal_cmd,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Synchronised pin levels; bit 0 is the memory clock.
  logic [7:0] pins_raw;
  logic [7:0] pins;
  logic [7:0] pins_rise;
  // Clock-enable level at the previous memory clock edge.
  logic cke_prev;
  // Current device state.
  sdpd_pkg::sdpd_state_t state;
  // Open rows per bank are tracked as one open flag.
  logic row_open;
  // Control register and exit counter.
  logic [31:0] ctrl;
  logic [7:0] exit_cnt;
  logic [7:0] read_wait;
  logic [7:0] nonread_wait;
  // Decoded command on this memory edge.
  logic [3:0] cmd;
  logic edge_hit;
  logic nop_cmd;
  // Bus handshake state.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Every pin passes two flip-flops before use.
  assign pins_raw = {a10, termination_control_pin, we_n, cas_n, ras_n,
                     cs_n, cke, mem_clk};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      sdpd_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(pins_raw[gi]),
        .dout(pins[gi]),
        .rise(pins_rise[gi])
      );
    end
  endgenerate

  // A memory clock rising edge is where the device samples its pins.
  assign edge_hit = pins_rise[0];
  // Command bits in package order: select, row, column, write strobes.
  assign cmd = pins[2] ? sdpd_pkg::CMD_NOP
                       : {1'b0, pins[3], pins[4], pins[5]};
  // Deselect and nop both count as nop.
  assign nop_cmd = (cmd == sdpd_pkg::CMD_NOP);

  // Previous clock-enable sample, updated on each memory edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_prev <= 1'b0;
    end else if (edge_hit) begin
      cke_prev <= pins[1]; // R25
    end
  end

  // Bank tracking from commands while clock enable stays high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_open <= 1'b0;
    end else if (edge_hit && cke_prev && pins[1]) begin
      if (cmd == sdpd_pkg::CMD_ACT) begin
        row_open <= 1'b1;
      end else if (cmd == sdpd_pkg::CMD_PRE && pins[7]) begin
        // Precharge all closes every row.
        row_open <= 1'b0;
      end else if (cmd == sdpd_pkg::CMD_PRE) begin
        // Single-bank precharge treated as closing the open row.
        row_open <= 1'b0;
      end else if ((cmd == sdpd_pkg::CMD_WR || cmd == sdpd_pkg::CMD_RD) &&
                   pins[7]) begin
        // Auto precharge closes the row, so a later entry is precharge.
        row_open <= 1'b0; // R18
      end
    end
  end

  // Clock-enable truth table decode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= sdpd_pkg::SDPD_IDLE;
    end else if (edge_hit) begin
      case (state)
        sdpd_pkg::SDPD_PRE_PD, sdpd_pkg::SDPD_ACT_PD: begin
          // Low enable keeps the state whatever the command.
          if (pins[1] && nop_cmd) begin // R11 R8
            state <= row_open ? sdpd_pkg::SDPD_ACTIVE
                              : sdpd_pkg::SDPD_IDLE;
          end
        end
        sdpd_pkg::SDPD_SELF_REF: begin
          if (pins[1] && nop_cmd) begin // R11 R8
            state <= sdpd_pkg::SDPD_IDLE;
          end
        end
        default: begin
          if (cke_prev && !pins[1]) begin
            if (cmd == sdpd_pkg::CMD_REF && !row_open) begin
              state <= sdpd_pkg::SDPD_SELF_REF; // R9
            end else if (nop_cmd) begin
              // Entry kind follows the bank state, so entry one clock
              // after an activate, refresh or precharge is accepted.
              state <= row_open ? sdpd_pkg::SDPD_ACT_PD
                                : sdpd_pkg::SDPD_PRE_PD; // R1 R20 R21 R22
            end
          end else if (pins[1]) begin
            state <= row_open ? sdpd_pkg::SDPD_ACTIVE
                              : sdpd_pkg::SDPD_IDLE;
          end
        end
      endcase
    end
  end

  // Flags an edge whose enable and command pair is not in the table.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      illegal_cmd <= 1'b0;
    end else if (edge_hit) begin
      illegal_cmd <= (cke_prev != pins[1]) && !nop_cmd &&
        !(cke_prev && cmd == sdpd_pkg::CMD_REF && !row_open); // R16
    end
  end

  // Exit delay counter, started on the exit edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exit_cnt <= 8'hff;
      read_wait <= 8'h00;
      nonread_wait <= 8'h00;
    end else if (edge_hit) begin
      if (!cke_prev && pins[1] && nop_cmd) begin
        exit_cnt <= 8'h00;
        if (state == sdpd_pkg::SDPD_SELF_REF) begin
          read_wait <= 8'(sdpd_pkg::SR_READ_CLK); // R10
          nonread_wait <= 8'(sdpd_pkg::SR_NONREAD_CLK);
        end else if (state == sdpd_pkg::SDPD_ACT_PD) begin
          read_wait <= ctrl[sdpd_pkg::CTRL_SLOW_EXIT]
            ? 8'(sdpd_pkg::SLOW_READ_CLK)  // R5
            : 8'(sdpd_pkg::FAST_READ_CLK); // R4
          nonread_wait <= 8'(sdpd_pkg::EXIT_NONREAD_CLK); // R3
        end else begin
          read_wait <= 8'(sdpd_pkg::EXIT_NONREAD_CLK);
          nonread_wait <= 8'(sdpd_pkg::EXIT_NONREAD_CLK); // R3
        end
      end else if (exit_cnt != 8'hff) begin
        exit_cnt <= exit_cnt + 8'h01;
      end
    end
  end

  // Readiness after an exit; the controller must honour it.
  assign read_ready = (state == sdpd_pkg::SDPD_IDLE ||
    state == sdpd_pkg::SDPD_ACTIVE) && (exit_cnt >= read_wait);
  assign nonread_ready = (state == sdpd_pkg::SDPD_IDLE ||
    state == sdpd_pkg::SDPD_ACTIVE) && (exit_cnt >= nonread_wait);

  // Device status outputs derived from state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      termination_on <= 1'b0;
      dll_frozen <= 1'b0;
      buffers_on <= 1'b1;
      refreshing <= 1'b0;
    end else begin
      // Termination follows the pin when enabled in the control register, unless in self refresh.
      termination_on <= ctrl[sdpd_pkg::CTRL_ODT_EN] && pins[6] &&
        state != sdpd_pkg::SDPD_SELF_REF; // R14
      dll_frozen <= (state == sdpd_pkg::SDPD_PRE_PD); // R24
      buffers_on <= (state == sdpd_pkg::SDPD_IDLE ||
        state == sdpd_pkg::SDPD_ACTIVE); // R24
      // Only self refresh refreshes; power-down does not.
      refreshing <= (state == sdpd_pkg::SDPD_SELF_REF); // R12
    end
  end

  // Write address and data are taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register write; writes elsewhere are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= sdpd_pkg::CTRL_RESET;
    end else if (aw_held && w_held && aw_addr == sdpd_pkg::REG_CTRL &&
                 w_strb[0]) begin
      ctrl <= {29'h0, w_data[2:0]};
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == sdpd_pkg::REG_CTRL) begin
        s_axi_rdata <= ctrl;
      end else if (s_axi_araddr == sdpd_pkg::REG_STATUS) begin
        s_axi_rdata <= {24'h0, illegal_cmd, nonread_ready, read_ready,
          row_open, cke_prev, 3'(state)};
      end else if (s_axi_araddr == sdpd_pkg::REG_EXITCNT) begin
        s_axi_rdata <= {24'h0, exit_cnt};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : sdpd_top

// >>> tb/sdpd_top_checker.sv
// Concurrent checks on the power-down outputs of the block.
`timescale 1ns/1ps
module sdpd_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic buffers_on,
  input wire logic dll_frozen,
  input wire logic refreshing,
  input wire logic termination_on,
  input wire logic read_ready,
  input wire logic nonread_ready
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // An exit restarts the delay counts, so nothing is ready at first.
  sequence s_exit;
    $rose(buffers_on);
  endsequence
  property p_sr_buf; refreshing |-> !buffers_on; endproperty
  property p_sr_term; refreshing |-> !termination_on; endproperty
  property p_frz_buf; dll_frozen |-> !buffers_on; endproperty
  property p_frz_sr; dll_frozen |-> !refreshing; endproperty
  property p_pd_busy; !buffers_on |-> !read_ready && !nonread_ready;
  endproperty
  property p_exit_rd; s_exit |-> !read_ready [*8]; endproperty
  property p_exit_nr; s_exit |-> !nonread_ready [*8]; endproperty
  property p_sr_rd; refreshing |-> !read_ready; endproperty
  a_sr_buf: assert property (p_sr_buf)
    else $error("Buffers on during self refresh");
  a_sr_term: assert property (p_sr_term)
    else $error("Termination on during self refresh");
  a_frz_buf: assert property (p_frz_buf)
    else $error("Loop frozen outside power-down");
  a_frz_sr: assert property (p_frz_sr)
    else $error("Loop frozen in self refresh");
  a_pd_busy: assert property (p_pd_busy)
    else $error("Ready while powered down");
  a_exit_rd: assert property (p_exit_rd)
    else $error("Read ready too soon after exit");
  a_exit_nr: assert property (p_exit_nr)
    else $error("Non-read ready too soon after exit");
  a_sr_rd: assert property (p_sr_rd)
    else $error("Read ready in self refresh");
endmodule : sdpd_top_checker
bind sdpd_top sdpd_top_checker u_chk (.aclk, .aresetn, .buffers_on,
  .dll_frozen, .refreshing, .termination_on, .read_ready, .nonread_ready);

// >>> tb/sdpd_ctl_model.sv
// Behavioural memory controller driving clock, enable and commands.
`timescale 1ns/1ps
module sdpd_ctl_model (
  output logic mem_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic a10,
  output logic termination_control_pin
);
  // The memory clock runs free, as power-down needs a stable clock.
  initial begin
    mem_clk = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = sdpd_pkg::CMD_NOP;
    a10 = 1'b1; // Precharges close all banks.
    termination_control_pin = 1'b1; // Driven valid throughout.
    forever #100 mem_clk = ~mem_clk;
  end
  // One memory edge: pins change mid-cycle, away from the sample edge.
  // Any enable and command pair can be driven; no mode-register load is ever issued.
  task automatic step(input logic k, input logic [3:0] c);
    @(negedge mem_clk);
    cke = k;
    {cs_n, ras_n, cas_n, we_n} = c;
    @(posedge mem_clk);
  endtask : step
  // Holds a level with no-operations for the given number of edges.
  task automatic hold(input logic k, input int n);
    repeat (n) step(k, sdpd_pkg::CMD_NOP);
  endtask : hold
endmodule : sdpd_ctl_model

// >>> tb/sdpd_top_bench.sv
// Self-checking bench of the power-down control block.
`timescale 1ns/1ps
module sdpd_top_bench;
  logic aclk, aresetn, mem_clk, cke, cs_n, ras_n, cas_n, we_n, a10, tpin;
  logic termination_on, dll_frozen, buffers_on, refreshing;
  logic read_ready, nonread_ready, illegal_cmd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int mismatches, tests_run, cyc;
  sdpd_ctl_model u_sdpd_ctl_model (.mem_clk, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .a10, .termination_control_pin(tpin));
  sdpd_top u_sdpd_top (.aclk, .aresetn, .mem_clk, .cke, .cs_n, .ras_n,
    .cas_n, .we_n, .a10, .termination_control_pin(tpin), .termination_on,
    .dll_frozen, .buffers_on, .refreshing, .read_ready, .nonread_ready,
    .illegal_cmd, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // AXI write: both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w && bvalid)) begin
      @(posedge aclk);
      if (!aw && awready) begin aw = 1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1; wvalid <= 1'b0; end
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  // AXI read: address held until taken, data taken with rvalid.
  task automatic rd(input logic [7:0] a);
    bit ar;
    ar = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!(ar && rvalid)) begin
      @(posedge aclk);
      if (!ar && arready) begin ar = 1; arvalid <= 1'b0; end
    end
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd
  // Lets the synchroniser and state update land after a memory edge.
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask : settle
  // Register reset value, unmapped read and termination enable.
  task automatic t_regs();
    rd(sdpd_pkg::REG_CTRL);
    chk("ctrl", sdpd_pkg::CTRL_RESET, rv);
    rd(8'h10);
    chk("unmapped", 32'h0, rv);
    chk("rresp", 32'h0, 32'(rs));
    wr(8'h10, 32'hffff_ffff);
    chk("bresp", 32'h0, 32'(rs));
    // The loop-locked bit stays set; the block stores it but never acts on it.
    wr(sdpd_pkg::REG_CTRL, 32'h6);
    settle();
    chk("term_on", 32'h1, 32'(termination_on));
  endtask : t_regs
  // Active power-down right after activate, then exit read delay.
  task automatic t_actpd(input logic [31:0] c, input int dly);
    wr(sdpd_pkg::REG_CTRL, c);
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_ACT);
    u_sdpd_ctl_model.hold(1'b0, 3);
    settle();
    chk("apd_buf", 32'h0, 32'(buffers_on));
    chk("apd_frz", 32'h0, 32'(dll_frozen));
    u_sdpd_ctl_model.hold(1'b1, dly);
    settle();
    chk("apd_rd_early", 32'h0, 32'(read_ready));
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_NOP);
    settle();
    chk("apd_rd", 32'h1, 32'(read_ready));
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_PRE);
    u_sdpd_ctl_model.hold(1'b1, 3);
  endtask : t_actpd
  // Precharge power-down one edge after a precharge or refresh.
  task automatic t_prepd(input logic [3:0] c);
    u_sdpd_ctl_model.step(1'b1, c);
    u_sdpd_ctl_model.hold(1'b0, 3);
    settle();
    chk("ppd_frz", 32'h1, 32'(dll_frozen));
    chk("ppd_buf", 32'h0, 32'(buffers_on));
    u_sdpd_ctl_model.hold(1'b1, 3);
  endtask : t_prepd
  // Self refresh entry, ignored commands, and the long exit delays.
  task automatic t_selfref();
    u_sdpd_ctl_model.step(1'b0, sdpd_pkg::CMD_REF);
    u_sdpd_ctl_model.step(1'b0, sdpd_pkg::CMD_ACT);
    u_sdpd_ctl_model.hold(1'b0, 2);
    settle();
    chk("sr_on", 32'h1, 32'(refreshing));
    chk("sr_term", 32'h0, 32'(termination_on));
    u_sdpd_ctl_model.hold(1'b1, sdpd_pkg::SR_READ_CLK);
    settle();
    chk("sr_rd_early", 32'h0, 32'(read_ready));
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_NOP);
    settle();
    chk("sr_rd", 32'h1, 32'(read_ready));
    chk("sr_nr", 32'h1, 32'(nonread_ready));
    rd(sdpd_pkg::REG_STATUS);
    chk("status", 32'h68, rv);
  endtask : t_selfref
  // Enable falling with a read is flagged as illegal.
  task automatic t_illegal();
    u_sdpd_ctl_model.step(1'b0, sdpd_pkg::CMD_RD);
    settle();
    chk("illegal", 32'h1, 32'(illegal_cmd));
    u_sdpd_ctl_model.hold(1'b0, 2);
    u_sdpd_ctl_model.hold(1'b1, 3);
  endtask : t_illegal
  // System clock and the hang limit.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc >= 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  // Main sequence.
  initial begin
    aresetn = 1'b0; awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0;
    wstrb = 4'hf; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0;
    mismatches = 0; tests_run = 0; cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    u_sdpd_ctl_model.hold(1'b1, 3);
    t_regs();
    t_actpd(32'h6, sdpd_pkg::FAST_READ_CLK);
    t_actpd(32'h7, sdpd_pkg::SLOW_READ_CLK);
    t_prepd(sdpd_pkg::CMD_PRE);
    t_prepd(sdpd_pkg::CMD_REF);
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_ACT);
    u_sdpd_ctl_model.step(1'b1, sdpd_pkg::CMD_WR);
    u_sdpd_ctl_model.hold(1'b1, 3);
    t_prepd(sdpd_pkg::CMD_NOP);
    t_selfref();
    t_illegal();
    print_verdict();
  end
endmodule : sdpd_top_bench
